// ==== design/inertial_event_debounce_detect.sv ====
// Freefall/motion and transient event detection with debounce and registers
`timescale 1ns/1ns
`default_nettype none
`include "event_regs.svh"
module inertial_event_debounce_detect #(
  parameter int unsigned BASE_TICK_CYCLES = `BASE_STEP_NS / `CLK_PERIOD_NS
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire logic [11:0] accel_x_in,
  input wire logic [11:0] accel_y_in,
  input wire logic [11:0] accel_z_in,
  input wire logic [11:0] filt_x_in,
  input wire logic [11:0] filt_y_in,
  input wire logic [11:0] filt_z_in,
  input wire logic [1:0] full_scale_in,
  input wire logic low_noise_in,
  input wire event_pkg::sample_rate_t sample_rate_in,
  input wire event_pkg::osr_mode_t osr_mode_in,
  input wire logic motion_or_select_in,
  input wire logic [2:0] motion_axis_enable_in,
  input wire logic motion_source_read_in,
  input wire logic transient_int_enable_in,
  output logic motion_event_out,
  output logic transient_int_out
);

  event_pkg::main_state_t s_q;
  event_pkg::main_state_t s_d;

  logic step;
  logic [7:0] motion_cnt;
  logic [7:0] trans_cnt;
  logic motion_reached;
  logic trans_reached;
  logic motion_debounced;
  logic trans_debounced;
  logic [6:0] motion_ths_eff;
  logic [6:0] trans_ths_eff;
  logic [2:0] motion_over;
  logic [2:0] trans_over;
  logic [2:0] trans_hit;
  logic [2:0] trans_sign;
  logic [2:0] trans_enable;
  logic latch_enable;
  logic src_read;
  logic wr_motion_ths;
  logic motion_cond_now;
  logic [11:0] trans_x;
  logic [11:0] trans_y;
  logic [11:0] trans_z;

  // Magnitude in 1/16 g units on an 8 g scale, whatever the output scale
  function automatic logic [7:0] axis_units(input logic [11:0] smp,
                                            input logic [1:0] fs);
    logic [11:0] mag;
    logic [11:0] scaled;
    mag = smp[11] ? (~smp + 12'h001) : smp;
    case (fs)
      2'h0: scaled = mag >> 2;
      2'h1: scaled = mag >> 1;
      default: scaled = mag;
    endcase
    axis_units = scaled[11:4];
  endfunction : axis_units

  // 0x40 counts is 4 g; the cap trades range for the quieter path
  function automatic logic [6:0] cap_ths(input logic [6:0] ths,
                                         input logic ln);
    if (ln && ths > `LN_THS_CAP) begin
      cap_ths = `LN_THS_CAP;
    end else begin
      cap_ths = ths;
    end
  endfunction : cap_ths

  assign motion_ths_eff = cap_ths(s_q.motion_threshold[6:0], low_noise_in);
  assign trans_ths_eff = cap_ths(s_q.transient_threshold[6:0],
                                 low_noise_in);

  // Unsigned 7-bit threshold against magnitude
  assign motion_over[0] = axis_units(accel_x_in, full_scale_in) >
                          {1'b0, motion_ths_eff};
  assign motion_over[1] = axis_units(accel_y_in, full_scale_in) >
                          {1'b0, motion_ths_eff};
  assign motion_over[2] = axis_units(accel_z_in, full_scale_in) >
                          {1'b0, motion_ths_eff};

  // Freefall needs at least one enabled axis to mean anything
  always_comb begin
    if (motion_or_select_in) begin
      motion_cond_now = |(motion_over & motion_axis_enable_in);
    end else begin
      motion_cond_now = (|motion_axis_enable_in) &&
                        ((motion_over & motion_axis_enable_in) == 3'h0);
    end
  end

  assign trans_x = s_q.transient_config[`BYPASS_BIT] ? accel_x_in
                                                     : filt_x_in;
  assign trans_y = s_q.transient_config[`BYPASS_BIT] ? accel_y_in
                                                     : filt_y_in;
  assign trans_z = s_q.transient_config[`BYPASS_BIT] ? accel_z_in
                                                     : filt_z_in;
  assign trans_sign = {trans_z[11], trans_y[11], trans_x[11]};
  assign trans_over[0] = axis_units(trans_x, full_scale_in) >
                         {1'b0, trans_ths_eff};
  assign trans_over[1] = axis_units(trans_y, full_scale_in) >
                         {1'b0, trans_ths_eff};
  assign trans_over[2] = axis_units(trans_z, full_scale_in) >
                         {1'b0, trans_ths_eff};
  assign trans_enable = {s_q.transient_config[`Z_EN_BIT],
                         s_q.transient_config[`Y_EN_BIT],
                         s_q.transient_config[`X_EN_BIT]};
  assign trans_hit = sample_valid_in ? (trans_over & trans_enable)
                                     : 3'h0;
  assign latch_enable = s_q.transient_config[`LATCH_BIT];
  assign src_read = reg_rd_in && (reg_addr_in == `TRANS_SRC_ADDR);
  assign wr_motion_ths = reg_wr_in && (reg_addr_in == `MOTION_THS_ADDR);

  step_timer #(
    .BASE_TICK_CYCLES(BASE_TICK_CYCLES)
  ) u_step (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .sample_rate_in(sample_rate_in),
    .osr_mode_in(osr_mode_in),
    .step_out(step)
  );

  debounce_counter u_motion_dbc (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .step_in(step),
    .cond_in(s_q.motion_cond),
    .debounce_mode_select_in(s_q.motion_threshold[`DBMODE_BIT]),
    .limit_in(s_q.motion_debounce_count),
    .clear_in(motion_source_read_in),
    .count_out(motion_cnt),
    .reached_out(motion_reached)
  );

  // Own counter, mode bit, threshold and count
  debounce_counter u_trans_dbc (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .step_in(step),
    .cond_in(s_q.trans_cond),
    .debounce_mode_select_in(s_q.transient_threshold[`DBMODE_BIT]),
    .limit_in(s_q.transient_debounce_count),
    .clear_in(src_read),
    .count_out(trans_cnt),
    .reached_out(trans_reached)
  );

  assign motion_debounced = motion_reached && s_q.motion_cond;
  assign trans_debounced = trans_reached && s_q.trans_cond;

  always_comb begin
    s_d = s_q;
    // Conditions sampled once per new sample, counted once per step
    if (sample_valid_in) begin
      s_d.motion_cond = motion_cond_now;
      s_d.trans_cond = |(trans_over & trans_enable);
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        `MOTION_THS_ADDR: s_d.motion_threshold = reg_wdata_in;
        `MOTION_COUNT_ADDR: s_d.motion_debounce_count = reg_wdata_in;
        `TRANS_CFG_ADDR: s_d.transient_config = reg_wdata_in[4:0];
        `TRANS_THS_ADDR: s_d.transient_threshold = reg_wdata_in;
        `TRANS_COUNT_ADDR: s_d.transient_debounce_count = reg_wdata_in;
        default: s_d.transient_config = s_q.transient_config;
      endcase
    end
    // Motion flag: the read wins, since it also restarts the count
    if (motion_source_read_in) begin
      s_d.motion_flag = 1'b0;
    end
    if (motion_debounced && !motion_source_read_in) begin
      s_d.motion_flag = 1'b1;
    end
    // Transient source: the read clears first, new events then apply
    if (src_read) begin
      s_d.event_active = 1'b0;
      s_d.axis_event = 3'h0;
      s_d.axis_pol = 3'h0;
    end
    if (!latch_enable) begin
      s_d.event_active = trans_debounced;
      if (sample_valid_in) begin
        s_d.axis_event = trans_hit;
        s_d.axis_pol = trans_hit & trans_sign;
      end
    end else if (s_d.event_active) begin
      // Latched: only new axes set, their polarity follows
      s_d.axis_event = s_d.axis_event | trans_hit;
      s_d.axis_pol = (s_d.axis_pol & ~trans_hit) |
                     (trans_hit & trans_sign);
    end else begin
      if (sample_valid_in) begin
        s_d.axis_event = trans_hit;
        s_d.axis_pol = trans_hit & trans_sign;
      end
      s_d.event_active = trans_debounced;
    end
    // Registered read data; unmapped addresses read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        `MOTION_THS_ADDR: s_d.rdata = s_q.motion_threshold;
        `MOTION_COUNT_ADDR: s_d.rdata = s_q.motion_debounce_count;
        `TRANS_CFG_ADDR: s_d.rdata = {3'h0, s_q.transient_config};
        `TRANS_SRC_ADDR: s_d.rdata = {1'b0, s_q.event_active,
                                      s_q.axis_event[2], s_q.axis_pol[2],
                                      s_q.axis_event[1], s_q.axis_pol[1],
                                      s_q.axis_event[0],
                                      s_q.axis_pol[0]};
        `TRANS_THS_ADDR: s_d.rdata = s_q.transient_threshold;
        `TRANS_COUNT_ADDR: s_d.rdata = s_q.transient_debounce_count;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign motion_event_out = s_q.motion_flag;
  assign transient_int_out = s_q.event_active &&
                             transient_int_enable_in;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_src_read_clears: assert property (
    src_read && trans_hit == 3'h0 && !trans_debounced
    |=> s_q.axis_event == 3'h0 && !transient_int_out)
    else $error("source read did not clear");

  chk_latched_no_clear: assert property (
    latch_enable && s_q.event_active && !src_read
    |=> (($past(s_q.axis_event) & ~s_q.axis_event) == 3'h0) &&
        s_q.event_active)
    else $error("latched axis bit cleared before read");

  chk_low_noise_cap: assert property (
    low_noise_in |-> trans_ths_eff <= `LN_THS_CAP &&
                     motion_ths_eff <= `LN_THS_CAP)
    else $error("threshold above 4 g under low noise");

  chk_disabled_axis: assert property (
    sample_valid_in && !latch_enable && !src_read
    |=> (s_q.axis_event & ~$past(trans_enable)) == 3'h0)
    else $error("disabled axis raised an event");

  chk_motion_flag_set: assert property (
    motion_debounced && !motion_source_read_in
    |=> motion_event_out [*2] or ##1 $past(motion_source_read_in))
    else $error("motion flag not set at debounce count");

  chk_int_with_event: assert property (
    trans_debounced && transient_int_enable_in && !src_read
    |=> transient_int_out)
    else $error("transient interrupt not raised");

  chk_motion_read_clr: assert property (
    motion_source_read_in |=> motion_cnt == 8'h00 && !motion_event_out)
    else $error("motion source read did not clear");

  chk_trans_cnt_clear: assert property (
    src_read |=> trans_cnt == 8'h00)
    else $error("transient counter not cleared by read");

  cov_motion_event: cover property (motion_debounced ##1 motion_event_out);
  cov_latched_add: cover property (
    latch_enable && s_q.event_active && trans_hit != 3'h0);
  cov_read_clear: cover property (src_read && s_q.event_active);
  cov_write_ths: cover property (wr_motion_ths);

endmodule : inertial_event_debounce_detect
`default_nettype wire

// ==== design/event_regs.svh ====
// Register map, field positions, reset values and timing of event detection
// How it works
// - Clear-mode resets counter when condition false
// - Step-mode decrements counter, floor zero
// - Threshold is unsigned 7 bits, 0.063 g
// - Comparison spans 8 g at any scale
// - Low-noise caps threshold at 4 g
// - Motion flag sets when counter reaches count
// - Counter saturates at programmed count
// - Step period follows rate and oversampling
// - Filter bypass selects unfiltered transient data
// - Enabled axes flag delta above threshold
// - Latch enable holds transient flags
// - Latched event-active still adds newly hit axes
// - Source read clears bits and interrupt
// - Latched axis bits hold while event-active, until a source read
// - Source layout: active bit6, Z Y X pairs
// - Event-active shows any enabled transient event
// - Transient threshold 7 bits, 8 g, 4 g
// - Threshold bit 7 selects debounce mode
// - Transient event raises flag and interrupt
// - Freefall all below, motion any above
// - Motion source read clears flag, counter
`ifndef EVENT_REGS_SVH
`define EVENT_REGS_SVH

`define MOTION_THS_ADDR 8'h17
`define MOTION_COUNT_ADDR 8'h18
`define TRANS_CFG_ADDR 8'h1d
`define TRANS_SRC_ADDR 8'h1e
`define TRANS_THS_ADDR 8'h1f
`define TRANS_COUNT_ADDR 8'h20

`define DBMODE_BIT 7
`define LATCH_BIT 4
`define Z_EN_BIT 3
`define Y_EN_BIT 2
`define X_EN_BIT 1
`define BYPASS_BIT 0
`define ACTIVE_BIT 6

`define REG_RESET 8'h00
`define LN_THS_CAP 7'h40

`define CLK_PERIOD_NS 10
`define BASE_STEP_NS 1250000

`endif

// ==== design/event_pkg.sv ====
// Types shared by the event detection modules
`default_nettype none
package event_pkg;

  typedef enum logic [2:0] {
    rate_800, rate_400, rate_200, rate_100,
    rate_50, rate_12p5, rate_6p25, rate_1p56
  } sample_rate_t;

  typedef enum logic [1:0] {
    normal_mode, low_power_low_noise_mode,
    high_resolution_mode, low_power_mode
  } osr_mode_t;

  typedef struct packed {
    logic [7:0] cnt;
  } debounce_state_t;

  typedef struct packed {
    logic [23:0] tick;
    logic [7:0] mult;
    logic step;
  } step_state_t;

  typedef struct packed {
    logic [7:0] motion_threshold;
    logic [7:0] motion_debounce_count;
    logic [4:0] transient_config;
    logic [7:0] transient_threshold;
    logic [7:0] transient_debounce_count;
    logic event_active;
    logic [2:0] axis_event;
    logic [2:0] axis_pol;
    logic motion_flag;
    logic motion_cond;
    logic trans_cond;
    logic [7:0] rdata;
  } main_state_t;

endpackage : event_pkg
`default_nettype wire

// ==== design/debounce_counter.sv ====
// Debounce counter with clear or decrement mode and saturation
`timescale 1ns/1ns
`default_nettype none
module debounce_counter (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic step_in,
  input wire logic cond_in,
  input wire logic debounce_mode_select_in,
  input wire logic [7:0] limit_in,
  input wire logic clear_in,
  output logic [7:0] count_out,
  output logic reached_out
);

  event_pkg::debounce_state_t s_q;
  event_pkg::debounce_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear_in) begin
      s_d.cnt = 8'h00;
    end else if (step_in) begin
      if (cond_in) begin
        if (s_q.cnt < limit_in) begin
          s_d.cnt = s_q.cnt + 8'h01;
        end else begin
          s_d.cnt = limit_in;
        end
      end else if (debounce_mode_select_in) begin
        s_d.cnt = 8'h00;
      end else if (s_q.cnt != 8'h00) begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.cnt;
  // Limit lowered below the count also counts as reached
  assign reached_out = (s_q.cnt >= limit_in);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_clear_mode_zero: assert property (
    step_in && !clear_in && !cond_in && debounce_mode_select_in
    |=> count_out == 8'h00)
    else $error("counter not cleared in clear mode");

  chk_step_mode_dec: assert property (
    step_in && !clear_in && !cond_in && !debounce_mode_select_in &&
    count_out != 8'h00 |=> count_out == $past(count_out) - 8'h01)
    else $error("counter did not decrement by one");

  chk_count_saturates: assert property (
    step_in && !clear_in && cond_in && count_out >= limit_in
    |=> count_out == $past(limit_in))
    else $error("counter passed the programmed count");

endmodule : debounce_counter
`default_nettype wire

// ==== design/step_timer.sv ====
// Debounce time step generator from sample rate and oversampling mode
`timescale 1ns/1ns
`default_nettype none
module step_timer #(
  parameter int unsigned BASE_TICK_CYCLES = 125000
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire event_pkg::sample_rate_t sample_rate_in,
  input wire event_pkg::osr_mode_t osr_mode_in,
  output logic step_out
);

  event_pkg::step_state_t s_q;
  event_pkg::step_state_t s_d;
  logic [7:0] ticks_per_step;

  // Step length in 1.25 ms base ticks
  always_comb begin
    ticks_per_step = 8'h10;
    case (sample_rate_in)
      event_pkg::rate_800: ticks_per_step = 8'h01;
      event_pkg::rate_400: ticks_per_step = 8'h02;
      event_pkg::rate_200: ticks_per_step = 8'h04;
      event_pkg::rate_100: ticks_per_step = 8'h08;
      event_pkg::rate_50: ticks_per_step = 8'h10;
      event_pkg::rate_12p5: begin
        if (osr_mode_in == event_pkg::normal_mode) begin
          ticks_per_step = 8'h10;
        end else begin
          ticks_per_step = 8'h40;
        end
      end
      default: begin
        case (osr_mode_in)
          event_pkg::normal_mode: ticks_per_step = 8'h10;
          event_pkg::low_power_low_noise_mode: ticks_per_step = 8'h40;
          default: ticks_per_step = 8'h80;
        endcase
      end
    endcase
    if (osr_mode_in == event_pkg::high_resolution_mode &&
        sample_rate_in != event_pkg::rate_800) begin
      ticks_per_step = 8'h02;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    if (s_q.tick >= 24'(BASE_TICK_CYCLES - 1)) begin
      s_d.tick = 24'h000000;
      if (s_q.mult >= ticks_per_step - 8'h01) begin
        s_d.mult = 8'h00;
        s_d.step = 1'b1;
      end else begin
        s_d.mult = s_q.mult + 8'h01;
      end
    end else begin
      s_d.tick = s_q.tick + 24'h000001;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_out = s_q.step;

endmodule : step_timer
`default_nettype wire

// ==== sim/host_model.sv ====
// Host model driving the register strobe port of the event block
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic core_clk_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  output logic rd_valid_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // Read data is valid right after the taking edge
  always @(posedge core_clk_in) begin
    rd_valid_out <= reg_rd_out;
  end

  task automatic acc(input logic wr, input logic [7:0] a, d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    @(negedge core_clk_in);
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    // Inverted after release so stale data never looks valid
    reg_wdata_out = ~d;
  endtask : acc
endmodule : host_model
`default_nettype wire

// ==== sim/inertial_event_debounce_detect_tb.sv ====
// Self-checking bench for the inertial event detection block
`timescale 1ns/1ns
`default_nettype none
module inertial_event_debounce_detect_tb;
  typedef struct {
    logic [7:0] a;
    logic [7:0] e;
  } note_t;
  note_t q[$];
  note_t cur;
  int n_errors = 0;
  int n_compared = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rd_valid, mev, tint, neg;
  logic sv = 1'b0;
  logic [11:0] ax = '0, ay = '0, az = '0, fx = '0, fy = '0, fz = '0;
  logic [11:0] v;
  logic [1:0] fs = 2'h2;
  logic ln = 1'b0, osel = 1'b1, msr = 1'b0, ien = 1'b1;
  logic [2:0] men = 3'h0;
  event_pkg::sample_rate_t rate = event_pkg::rate_800;
  event_pkg::osr_mode_t osr = event_pkg::normal_mode;
  logic [7:0] regs[7] = '{8'h17, 8'h18, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h05};
  int rt[9] = '{0, 2, 3, 5, 7, 1, 4, 6, 0};
  int om[9] = '{0, 2, 0, 1, 3, 0, 0, 1, 2};
  int kk[9] = '{1, 2, 8, 64, 128, 2, 16, 64, 1};

  always #5 clk = ~clk;

  // Base tick of 4 cycles keeps the slowest rate short
  inertial_event_debounce_detect #(.BASE_TICK_CYCLES(4)) DUT (
    .core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .sample_valid_in(sv),
    .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az),
    .filt_x_in(fx), .filt_y_in(fy), .filt_z_in(fz),
    .full_scale_in(fs), .low_noise_in(ln), .sample_rate_in(rate),
    .osr_mode_in(osr), .motion_or_select_in(osel),
    .motion_axis_enable_in(men), .motion_source_read_in(msr),
    .transient_int_enable_in(ien), .motion_event_out(mev),
    .transient_int_out(tint)
  );

  host_model host (
    .core_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata), .rd_valid_out(rd_valid)
  );

  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic flag(input string nm, input logic f, e);
    check(nm, {7'h00, f}, {7'h00, e});
  endtask : flag

  task automatic rx(input logic [7:0] a, e);
    q.push_back('{a, e});
    host.acc(1'b0, a, 8'h00);
  endtask : rx

  task automatic wx(input logic [7:0] a, d);
    host.acc(1'b1, a, d);
  endtask : wx

  // One-cycle sample; values go either to raw or to filtered inputs
  task automatic smp(input logic [11:0] x, y, z, input logic to_f);
    @(negedge clk);
    {ax, ay, az} = to_f ? 36'h0 : {x, y, z};
    {fx, fy, fz} = to_f ? {x, y, z} : 36'h0;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    repeat (3) @(negedge clk);
  endtask : smp

  task automatic pulse();
    @(negedge clk);
    msr = 1'b1;
    @(negedge clk);
    msr = 1'b0;
  endtask : pulse

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (q.size() == 0) begin
        n_errors++;
        $display("[FAIL] read data expected none seen %h", rdata);
      end else begin
        cur = q.pop_front();
        check($sformatf("reg %h", cur.a), rdata, cur.e);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(14));
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    foreach (regs[i]) rx(regs[i], 8'h00);
    wx(8'h1d, 8'hff);
    rx(8'h1d, 8'h1f);
    wx(8'h18, 8'ha5);
    rx(8'h18, 8'ha5);
    wx(8'h17, 8'h5a);
    rx(8'h17, 8'h5a);
    wx(8'h1e, 8'hff);
    wx(8'h05, 8'hff);
    rx(8'h1e, 8'h00);
    rx(8'h05, 8'h00);
    // Latched transient: boundary, new axis added while active
    wx(8'h1f, 8'h10);
    wx(8'h20, 8'h00);
    smp(12'h100, '0, '0, 0);
    smp(12'h110, '0, '0, 0);
    smp('0, 12'he00, '0, 0);
    smp('0, '0, '0, 0);
    flag("int", tint, 1'b1);
    rx(8'h1e, 8'h4e);
    flag("int", tint, 1'b0);
    rx(8'h1e, 8'h00);
    ien = 1'b0;
    smp('0, '0, 12'h200, 0);
    smp('0, '0, '0, 0);
    flag("int", tint, 1'b0);
    ien = 1'b1;
    @(negedge clk);
    flag("int", tint, 1'b1);
    rx(8'h1e, 8'h60);
    wx(8'h1d, 8'h13);
    smp('0, 12'h200, 12'h200, 0);
    smp(12'h200, '0, '0, 1);
    rx(8'h1e, 8'h00);
    wx(8'h1d, 8'h12);
    smp(12'h200, '0, '0, 0);
    smp(12'he00, '0, '0, 1);
    smp('0, '0, '0, 0);
    rx(8'h1e, 8'h43);
    wx(8'h1d, 8'h13);
    fs = 2'h0;
    smp(12'h400, '0, '0, 0);
    rx(8'h1e, 8'h00);
    smp(12'h440, '0, '0, 0);
    smp('0, '0, '0, 0);
    rx(8'h1e, 8'h42);
    fs = 2'h2;
    ln = 1'b1;
    wx(8'h1f, 8'h7f);
    smp(12'h410, '0, '0, 0);
    smp('0, '0, '0, 0);
    rx(8'h1e, 8'h42);
    ln = 1'b0;
    smp(12'h410, '0, '0, 0);
    rx(8'h1e, 8'h00);
    wx(8'h1f, 8'h10);
    wx(8'h1d, 8'h03);
    smp(12'h200, '0, '0, 0);
    rx(8'h1e, 8'h42);
    smp('0, '0, '0, 0);
    rx(8'h1e, 8'h00);
    wx(8'h1d, 8'h13);
    repeat (8) begin
      v = 12'($urandom_range(0, 2047));
      neg = 1'($urandom_range(0, 1));
      smp(neg ? -v : v, '0, '0, 0);
      smp('0, '0, '0, 0);
      rx(8'h1e, (v[10:4] > 7'h10) ? {7'h21, neg} : 8'h00);
    end
    // Motion debounce: a short dip decrements in one mode, clears in other
    men = 3'b001;
    wx(8'h18, 8'h08);
    for (int m = 0; m < 2; m++) begin
      wx(8'h17, {m[0], 7'h10});
      smp('0, '0, '0, 0);
      pulse();
      smp(12'h200, '0, '0, 0);
      repeat (22) @(negedge clk);
      flag("motion", mev, 1'b0);
      smp('0, '0, '0, 0);
      smp(12'h200, '0, '0, 0);
      repeat (18) @(negedge clk);
      flag("motion", mev, !m[0]);
    end
    repeat (20) @(negedge clk);
    flag("motion", mev, 1'b1);
    pulse();
    flag("motion", mev, 1'b0);
    repeat (20) @(negedge clk);
    flag("motion", mev, 1'b0);
    repeat (20) @(negedge clk);
    flag("motion", mev, 1'b1);
    wx(8'h18, 8'h02);
    for (int i = 0; i < 9; i++) begin
      rate = event_pkg::sample_rate_t'(3'(rt[i]));
      osr = event_pkg::osr_mode_t'(2'(om[i]));
      pulse();
      repeat (2 * kk[i]) @(negedge clk);
      flag("motion", mev, 1'b0);
      repeat (6 * kk[i] + 4) @(negedge clk);
      flag("motion", mev, 1'b1);
    end
    rate = event_pkg::rate_800;
    osr = event_pkg::normal_mode;
    wx(8'h18, 8'h00);
    osel = 1'b0;
    men = 3'b011;
    smp('0, 12'h300, '0, 0);
    pulse();
    repeat (8) @(negedge clk);
    flag("motion", mev, 1'b0);
    smp('0, '0, 12'h7ff, 0);
    repeat (8) @(negedge clk);
    flag("motion", mev, 1'b1);
    // Transient count of three: its own counter, motion count is zero
    rx(8'h1e, 8'h42);
    wx(8'h20, 8'h03);
    rx(8'h20, 8'h03);
    smp(12'h200, '0, '0, 0);
    flag("int", tint, 1'b0);
    repeat (10) @(negedge clk);
    flag("int", tint, 1'b1);
    rx(8'h1e, 8'h42);
    repeat (4) @(negedge clk);
    // A read that never answered is a failure too
    if (q.size() != 0) n_errors++;
    conclude();
  end
endmodule : inertial_event_debounce_detect_tb
`default_nettype wire
